// [core/xym_pkg.sv]
package xym_pkg;
   // Register map on the AXI4-Lite slave, byte addresses
   localparam logic [11:0] XYM_OFS_CTRL = 12'h000;
   localparam logic [11:0] XYM_OFS_STAT = 12'h004;
   localparam logic [4:0] XYM_CTRL_RST = 5'h00;
   localparam logic [31:0] XYM_STAT_RST = 32'h00000000;

   // Field positions inside the control register
   localparam int unsigned XYM_CTRL_PRIV = 0;
   localparam int unsigned XYM_CTRL_DSP = 1;
   localparam int unsigned XYM_CTRL_CACHE = 2;
   localparam int unsigned XYM_CTRL_XLAT = 3;
   localparam int unsigned XYM_CTRL_SLEEP = 4;

   // AXI response codes
   localparam logic [1:0] XYM_RESP_OKAY = 2'h0;
   localparam logic [1:0] XYM_RESP_SLVERR = 2'h2;

   // Address layout: upper half selects X or Y, nibble 15:12 selects the page
   localparam logic [15:0] XYM_LOC_X_HI = 16'hA500;
   localparam logic [15:0] XYM_LOC_Y_HI = 16'hA501;
   localparam logic [15:0] XYM_PHYS_MASK = 16'h1FFF;
   localparam logic [3:0] XYM_PG0_NIB = 4'h7;
   localparam logic [3:0] XYM_PG1_NIB = 4'h8;
   localparam int unsigned XYM_IDX_W = 10;

   // Internal to bus clock ratio: cycles a system bus access waits at least
   localparam logic [3:0] XYM_SYS_RATIO = 4'h4;
   localparam logic [3:0] XYM_SYS_WAIT_CYC = XYM_SYS_RATIO - 4'h1;

   // System bus port sequencer
   typedef enum logic [2:0] {
      XYM_SYS_IDLE = 3'h1,
      XYM_SYS_WAIT = 3'h2,
      XYM_SYS_ACC = 3'h4
   } xym_sys_e;

   // Page decode of the low half: {valid, page}
   function automatic logic [1:0] xym_pg_of(input logic [15:0] lo);
      logic ok;
      ok = (lo[15:12] == XYM_PG0_NIB) || (lo[15:12] == XYM_PG1_NIB);
      return {ok, lo[15:12] == XYM_PG1_NIB};
   endfunction
endpackage

// [core/xym_page.sv]
module xym_page
   import xym_pkg::*;
(
   input wire logic aclk,
   input wire logic sys_req,
   input wire logic sys_we,
   input wire logic [3:0] sys_be,
   input wire logic [XYM_IDX_W-1:0] sys_idx,
   input wire logic [31:0] sys_wdata,
   input wire logic op_req,
   input wire logic op_we,
   input wire logic [XYM_IDX_W-1:0] op_idx,
   input wire logic [31:0] op_wdata,
   input wire logic loc_req,
   input wire logic loc_we,
   input wire logic [3:0] loc_be,
   input wire logic [XYM_IDX_W-1:0] loc_idx,
   input wire logic [31:0] loc_wdata,
   output logic sys_gnt,
   output logic op_gnt,
   output logic loc_gnt,
   output logic [31:0] sys_rd,
   output logic [31:0] op_rd,
   output logic [31:0] loc_rd,
   output logic conflict
);
   logic [31:0] mem [0:(1<<XYM_IDX_W)-1];
   logic wr_en;
   logic [3:0] wr_be;
   logic [XYM_IDX_W-1:0] wr_idx;
   logic [31:0] wr_data;

   // Fixed priority: system bus, then operand bus, then local bus
   always_comb
   begin
      sys_gnt = sys_req;
      op_gnt = op_req && !sys_req;
      loc_gnt = loc_req && !sys_req && !op_req;
      conflict = (sys_req && (op_req || loc_req)) || (op_req && loc_req);
      wr_en = 1'b0;
      wr_be = loc_be;
      wr_idx = loc_idx;
      wr_data = loc_wdata;
      if (sys_gnt)
      begin
         wr_en = sys_we;
         wr_be = sys_be;
         wr_idx = sys_idx;
         wr_data = sys_wdata;
      end
      else if (op_gnt)
      begin
         wr_en = op_we;
         wr_be = 4'hF;
         wr_idx = op_idx;
         wr_data = op_wdata;
      end
      else if (loc_gnt)
      begin
         wr_en = loc_we;
      end
   end

   // Reads are asynchronous so the owner captures data in its grant cycle
   assign sys_rd = mem[sys_idx];
   assign op_rd = mem[op_idx];
   assign loc_rd = mem[loc_idx];

   // Byte-lane write of the granted port only
   always_ff @(posedge aclk)
   begin
      for (int b = 0; b < 4; b++)
      begin
         if (wr_en && wr_be[b])
            mem[wr_idx][8*b +: 8] <= wr_data[8*b +: 8];
      end
   end
endmodule

// [core/xym_multiport.sv]
// Contract
// - Local bus access completes in one cycle when its page is free
// - System bus accesses take several cycles set by clock ratio and arbitration
// - Privileged mode reaches memory directly on the local bus
// - User DSP mode reaches memory directly on the local bus
// - Plain user mode gets no direct local access; only translated system bus
// - X and Y transfers use operand buses, one cycle when page is free
// - X operand and Y operand accesses proceed together without interference
// - DSP single transfers use the local or system bus with their timing
// - Privileged DSP single transfers reach memory directly from local bus
// - DMA engines use system bus with physical address, top three bits clear
// - Simultaneous accesses to one page all complete, serialized
// - Accesses to different pages or memories proceed concurrently
// - System bus accesses wait for system bus arbitration
// - In sleep mode system bus masters are not served
// - Address error writes may corrupt data; they are refused here
// - Page priority: system bus, then operand bus, then local bus
// - Operand buses decode only the low 16 address bits
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
module xym_multiport
   import xym_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite register slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Local bus from CPU and DSP single transfers
   input wire logic loc_req,
   input wire logic loc_we,
   input wire logic [3:0] loc_be,
   input wire logic [31:0] loc_addr,
   input wire logic [31:0] loc_wdata,
   output logic loc_ack,
   output logic loc_err,
   output logic [31:0] loc_rdata,
   // X and Y operand buses, word access
   input wire logic xop_req,
   input wire logic xop_we,
   input wire logic [31:0] xop_addr,
   input wire logic [31:0] xop_wdata,
   output logic xop_ack,
   output logic xop_err,
   output logic [31:0] xop_rdata,
   input wire logic yop_req,
   input wire logic yop_we,
   input wire logic [31:0] yop_addr,
   input wire logic [31:0] yop_wdata,
   output logic yop_ack,
   output logic yop_err,
   output logic [31:0] yop_rdata,
   // Shared physical system bus slave port
   input wire logic sys_req,
   input wire logic sys_we,
   input wire logic [3:0] sys_be,
   input wire logic [31:0] sys_addr,
   input wire logic [31:0] sys_wdata,
   output logic sys_ack,
   output logic sys_err,
   output logic [31:0] sys_rdata,
   output logic sys_bus_req,
   input wire logic sys_bus_gnt
);
   logic [4:0] ctrl_q, ctrl_d;
   logic [15:0] conf_cnt_q, conf_cnt_d;
   logic [15:0] refuse_cnt_q, refuse_cnt_d;
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic loc_ack_q, loc_ack_d, loc_err_q, loc_err_d;
   logic xop_ack_q, xop_ack_d, xop_err_q, xop_err_d;
   logic yop_ack_q, yop_ack_d, yop_err_q, yop_err_d;
   logic sys_ack_q, sys_ack_d, sys_err_q, sys_err_d;
   logic [31:0] loc_rdata_q, loc_rdata_d, xop_rdata_q, xop_rdata_d;
   logic [31:0] yop_rdata_q, yop_rdata_d, sys_rdata_q, sys_rdata_d;
   xym_sys_e sys_st_q, sys_st_d;
   logic [3:0] sys_cnt_q, sys_cnt_d;
   logic [1:0] sys_tgt_q, sys_tgt_d;
   logic sys_we_q, sys_we_d, sys_bus_req_q, sys_bus_req_d;
   logic [3:0] sys_be_q, sys_be_d;
   logic [31:0] sys_addr_q, sys_addr_d, sys_wdata_q, sys_wdata_d;
   logic [1:0] loc_dec, xop_dec, yop_dec, sys_dec;
   logic loc_hit, loc_mode_ok, loc_go, loc_bad, xop_go, xop_bad, yop_go, yop_bad;
   logic sys_hit, sys_go, sys_bad;
   logic [1:0] loc_tgt, xop_tgt, yop_tgt;
   logic [3:0] pg_sys_req, pg_op_req, pg_loc_req, pg_sys_gnt, pg_op_gnt, pg_loc_gnt;
   logic [3:0] pg_conf;
   logic [3:0][31:0] pg_sys_rd, pg_op_rd, pg_loc_rd;

   // Request decode; a requester holding req in its ack cycle is not reissued
   always_comb
   begin
      loc_dec = xym_pg_of(loc_addr[15:0]);
      loc_hit = ((loc_addr[31:16] == XYM_LOC_X_HI) || (loc_addr[31:16] == XYM_LOC_Y_HI))
         && loc_dec[1];
      loc_mode_ok = ctrl_q[XYM_CTRL_PRIV] || ctrl_q[XYM_CTRL_DSP];
      loc_tgt = {loc_addr[31:16] == XYM_LOC_Y_HI, loc_dec[0]};
      loc_go = loc_req && !loc_ack_q && loc_mode_ok && loc_hit && (loc_addr[1:0] == 2'h0);
      loc_bad = loc_req && !loc_ack_q && !loc_go;
      xop_dec = xym_pg_of(xop_addr[15:0]);
      yop_dec = xym_pg_of(yop_addr[15:0]);
      xop_tgt = {1'b0, xop_dec[0]};
      yop_tgt = {1'b1, yop_dec[0]};
      xop_go = xop_req && !xop_ack_q && xop_dec[1] && (xop_addr[1:0] == 2'h0);
      xop_bad = xop_req && !xop_ack_q && !xop_go;
      yop_go = yop_req && !yop_ack_q && yop_dec[1] && (yop_addr[1:0] == 2'h0);
      yop_bad = yop_req && !yop_ack_q && !yop_go;
      sys_dec = xym_pg_of(sys_addr[15:0]);
      sys_hit = (sys_addr[31:29] == 3'h0) && sys_dec[1] && (sys_addr[1:0] == 2'h0) &&
         ((sys_addr[31:16] == (XYM_LOC_X_HI & XYM_PHYS_MASK)) ||
          (sys_addr[31:16] == (XYM_LOC_Y_HI & XYM_PHYS_MASK)));
      sys_go = sys_req && !sys_ack_q && sys_hit && !ctrl_q[XYM_CTRL_SLEEP];
      sys_bad = sys_req && !sys_ack_q && !sys_go && (sys_st_q == XYM_SYS_IDLE);
   end

   // Page request vectors: X operand feeds X pages, Y operand feeds Y pages
   always_comb
   begin
      for (int p = 0; p < 4; p++)
      begin
         pg_loc_req[p] = loc_go && (loc_tgt == 2'(p));
         pg_op_req[p] = (xop_go && (xop_tgt == 2'(p))) || (yop_go && (yop_tgt == 2'(p)));
         pg_sys_req[p] = (sys_st_q == XYM_SYS_ACC) && (sys_tgt_q == 2'(p));
      end
   end

   // Four pages, each with its own three ports so distinct pages never collide
   for (genvar p = 0; p < 4; p++)
   begin : g_page
      xym_page u_page (
         .aclk(aclk),
         .sys_req(pg_sys_req[p]),
         .sys_we(sys_we_q),
         .sys_be(sys_be_q),
         .sys_idx(sys_addr_q[XYM_IDX_W+1:2]),
         .sys_wdata(sys_wdata_q),
         .op_req(pg_op_req[p]),
         .op_we(p < 2 ? xop_we : yop_we),
         .op_idx(p < 2 ? xop_addr[XYM_IDX_W+1:2] : yop_addr[XYM_IDX_W+1:2]),
         .op_wdata(p < 2 ? xop_wdata : yop_wdata),
         .loc_req(pg_loc_req[p]),
         .loc_we(loc_we),
         .loc_be(loc_be),
         .loc_idx(loc_addr[XYM_IDX_W+1:2]),
         .loc_wdata(loc_wdata),
         .sys_gnt(pg_sys_gnt[p]),
         .op_gnt(pg_op_gnt[p]),
         .loc_gnt(pg_loc_gnt[p]),
         .sys_rd(pg_sys_rd[p]),
         .op_rd(pg_op_rd[p]),
         .loc_rd(pg_loc_rd[p]),
         .conflict(pg_conf[p])
      );
   end

   // Answers for the single-cycle ports; a loser keeps its req and retries
   always_comb
   begin
      loc_ack_d = (loc_go && pg_loc_gnt[loc_tgt]) || loc_bad;
      loc_err_d = loc_bad;
      loc_rdata_d = (loc_go && pg_loc_gnt[loc_tgt]) ? pg_loc_rd[loc_tgt] : loc_rdata_q;
      xop_ack_d = (xop_go && pg_op_gnt[xop_tgt]) || xop_bad;
      xop_err_d = xop_bad;
      xop_rdata_d = (xop_go && pg_op_gnt[xop_tgt]) ? pg_op_rd[xop_tgt] : xop_rdata_q;
      yop_ack_d = (yop_go && pg_op_gnt[yop_tgt]) || yop_bad;
      yop_err_d = yop_bad;
      yop_rdata_d = (yop_go && pg_op_gnt[yop_tgt]) ? pg_op_rd[yop_tgt] : yop_rdata_q;
   end

   // System bus port: capture, wait ratio and arbitration, then one page cycle
   always_comb
   begin
      sys_st_d = sys_st_q;
      sys_cnt_d = sys_cnt_q;
      sys_tgt_d = sys_tgt_q;
      sys_we_d = sys_we_q;
      sys_be_d = sys_be_q;
      sys_addr_d = sys_addr_q;
      sys_wdata_d = sys_wdata_q;
      sys_bus_req_d = 1'b0;
      sys_ack_d = 1'b0;
      sys_err_d = 1'b0;
      sys_rdata_d = sys_rdata_q;
      case (sys_st_q)
         XYM_SYS_IDLE:
         begin
            if (sys_go)
            begin
               sys_st_d = XYM_SYS_WAIT;
               sys_cnt_d = XYM_SYS_WAIT_CYC;
               sys_tgt_d = {sys_addr[16], sys_dec[0]};
               sys_we_d = sys_we;
               sys_be_d = sys_be;
               sys_addr_d = sys_addr;
               sys_wdata_d = sys_wdata;
               sys_bus_req_d = 1'b1;
            end
            else if (sys_bad)
            begin
               sys_ack_d = 1'b1;
               sys_err_d = 1'b1;
            end
         end
         XYM_SYS_WAIT:
         begin
            sys_bus_req_d = 1'b1;
            if (sys_cnt_q != 4'h0)
               sys_cnt_d = sys_cnt_q - 4'h1;
            else if (sys_bus_gnt)
            begin
               sys_st_d = XYM_SYS_ACC;
               sys_bus_req_d = 1'b0;
            end
         end
         XYM_SYS_ACC:
         begin
            sys_st_d = XYM_SYS_IDLE; // Top priority, so the page is always granted
            sys_ack_d = 1'b1;
            sys_rdata_d = pg_sys_rd[sys_tgt_q];
         end
         default:
            sys_st_d = XYM_SYS_IDLE;
      endcase
   end

   // Status counters: page conflict cycles and cycles with a refused access
   always_comb
   begin
      conf_cnt_d = conf_cnt_q + {15'h0000, |pg_conf};
      refuse_cnt_d = refuse_cnt_q + {15'h0000, loc_bad || xop_bad || yop_bad || sys_bad};
   end

   // AXI4-Lite slave; write lands one cycle after both halves are held
   always_comb
   begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      ctrl_d = ctrl_q;
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_awvalid && awready_q)
      begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (aw_have_q && w_have_q && !bvalid_q)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = XYM_RESP_OKAY;
         if (awaddr_q[11:2] == XYM_OFS_CTRL[11:2])
         begin
            if (wstrb_q[0])
               ctrl_d = wdata_q[4:0];
         end
         else if (awaddr_q[11:2] != XYM_OFS_STAT[11:2])
            bresp_d = XYM_RESP_SLVERR;
      end
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
      if (s_axi_arvalid && arready_q)
      begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = XYM_RESP_OKAY;
         rdata_d = 32'h00000000;
         if (s_axi_araddr[11:2] == XYM_OFS_CTRL[11:2])
            rdata_d = {27'h0000000, ctrl_q};
         else if (s_axi_araddr[11:2] == XYM_OFS_STAT[11:2])
            rdata_d = {refuse_cnt_q, conf_cnt_q};
         else
            rresp_d = XYM_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end

   // All state registers; synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= XYM_CTRL_RST;
         {refuse_cnt_q, conf_cnt_q} <= XYM_STAT_RST;
         {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= 4'h0;
         {awready_q, wready_q, arready_q} <= 3'h7;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bresp_q <= XYM_RESP_OKAY;
         rresp_q <= XYM_RESP_OKAY;
         rdata_q <= 32'h00000000;
         {loc_ack_q, loc_err_q, xop_ack_q, xop_err_q} <= 4'h0;
         {yop_ack_q, yop_err_q, sys_ack_q, sys_err_q} <= 4'h0;
         loc_rdata_q <= 32'h00000000;
         xop_rdata_q <= 32'h00000000;
         yop_rdata_q <= 32'h00000000;
         sys_rdata_q <= 32'h00000000;
         sys_st_q <= XYM_SYS_IDLE;
         sys_cnt_q <= 4'h0;
         sys_tgt_q <= 2'h0;
         {sys_we_q, sys_bus_req_q} <= 2'h0;
         sys_be_q <= 4'h0;
         sys_addr_q <= 32'h00000000;
         sys_wdata_q <= 32'h00000000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         conf_cnt_q <= conf_cnt_d;
         refuse_cnt_q <= refuse_cnt_d;
         {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= {aw_have_d, w_have_d, bvalid_d, rvalid_d};
         {awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         {loc_ack_q, loc_err_q, xop_ack_q, xop_err_q} <= {loc_ack_d, loc_err_d, xop_ack_d, xop_err_d};
         {yop_ack_q, yop_err_q, sys_ack_q, sys_err_q} <= {yop_ack_d, yop_err_d, sys_ack_d, sys_err_d};
         loc_rdata_q <= loc_rdata_d;
         xop_rdata_q <= xop_rdata_d;
         yop_rdata_q <= yop_rdata_d;
         sys_rdata_q <= sys_rdata_d;
         sys_st_q <= sys_st_d;
         sys_cnt_q <= sys_cnt_d;
         sys_tgt_q <= sys_tgt_d;
         {sys_we_q, sys_bus_req_q} <= {sys_we_d, sys_bus_req_d};
         sys_be_q <= sys_be_d;
         sys_addr_q <= sys_addr_d;
         sys_wdata_q <= sys_wdata_d;
      end
   end

   // Outputs straight from registers
   assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} =
      {awready_q, wready_q, bvalid_q, bresp_q};
   assign {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata} =
      {arready_q, rvalid_q, rresp_q, rdata_q};
   assign {loc_ack, loc_err, loc_rdata} = {loc_ack_q, loc_err_q, loc_rdata_q};
   assign {xop_ack, xop_err, xop_rdata} = {xop_ack_q, xop_err_q, xop_rdata_q};
   assign {yop_ack, yop_err, yop_rdata} = {yop_ack_q, yop_err_q, yop_rdata_q};
   assign {sys_ack, sys_err, sys_rdata} = {sys_ack_q, sys_err_q, sys_rdata_q};
   assign sys_bus_req = sys_bus_req_q;

   // Checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_loc_one;
      (loc_go && !pg_sys_req[loc_tgt] && !pg_op_req[loc_tgt]) |=> loc_ack && !loc_err;
   endproperty
   a_loc_one: assert property (p_loc_one) else $error("free local access not done in one cycle");
   property p_sys_multi;
      (sys_st_q == XYM_SYS_IDLE && sys_go) |=> !sys_ack ##1 !sys_ack ##1 !sys_ack;
   endproperty
   a_sys_multi: assert property (p_sys_multi) else $error("system bus answered too soon");
   property p_user_refused;
      (loc_req && !loc_ack_q && !ctrl_q[XYM_CTRL_PRIV] && !ctrl_q[XYM_CTRL_DSP]) |=>
         loc_ack && loc_err;
   endproperty
   a_user_refused: assert property (p_user_refused) else $error("user mode direct access served");
   property p_op_pair;
      (xop_go && yop_go && pg_sys_req == 4'h0) |=> xop_ack && yop_ack && !xop_err && !yop_err;
   endproperty
   a_op_pair: assert property (p_op_pair) else $error("X and Y operand accesses interfered");
   property p_sys_wait_gnt;
      (sys_st_q == XYM_SYS_WAIT && sys_cnt_q == 4'h0 && !sys_bus_gnt) |=>
         sys_st_q == XYM_SYS_WAIT && sys_bus_req;
   endproperty
   a_sys_wait_gnt: assert property (p_sys_wait_gnt) else $error("system access skipped arbitration");
   property p_sleep;
      (ctrl_q[XYM_CTRL_SLEEP] && sys_req && !sys_ack_q && sys_st_q == XYM_SYS_IDLE) |=> sys_err;
   endproperty
   a_sleep: assert property (p_sleep) else $error("system access served in sleep");
   property p_prio;
      (loc_go && (pg_sys_req[loc_tgt] || pg_op_req[loc_tgt])) |=> !loc_ack;
   endproperty
   a_prio: assert property (p_prio) else $error("local bus beat higher priority bus");
   property p_retry;
      (loc_go && (pg_sys_req[loc_tgt] || pg_op_req[loc_tgt])) |=>
         (loc_req && $stable(loc_addr)) |-> loc_go;
   endproperty
   a_retry: assert property (p_retry) else $error("stalled local access dropped");
   property p_op_one;
      (xop_go && !pg_sys_req[xop_tgt]) |=> xop_ack && !xop_err;
   endproperty
   a_op_one: assert property (p_op_one) else $error("free X operand access not done");

   c_loc: cover property (loc_go ##1 loc_ack);
   c_conf: cover property (loc_go && pg_op_req[loc_tgt] ##1 !loc_ack ##1 loc_ack);
   c_sys: cover property (sys_st_q == XYM_SYS_ACC ##1 sys_ack && !sys_err);
   c_sleep: cover property (sys_bad && ctrl_q[XYM_CTRL_SLEEP]);
endmodule

// [test/xym_arb_model.sv]
module xym_arb_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] hold_cyc,
   input wire logic sys_bus_req,
   output logic sys_bus_gnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] busy_q;
   // Other masters keep the shared bus hold_cyc cycles into each request
   always_ff @(posedge aclk)
      if (!aresetn || !sys_bus_req) busy_q <= '0;
      else if (busy_q != hold_cyc) busy_q <= busy_q + 4'h1;
   assign sys_bus_gnt = sys_bus_req && busy_q == hold_cyc;
endmodule

// [test/tb_xy_multiport_memory_access.sv]
module tb_xy_multiport_memory_access
   import xym_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = '0;
   logic aresetn = '0;
   logic [3:0] hold_cyc = '0;
   logic [31:0] s_axi_wdata = '0, loc_addr = '0, loc_wdata = '0, xop_addr = '0, xop_wdata = '0;
   logic [31:0] yop_addr = '0, yop_wdata = '0, sys_addr = '0, sys_wdata = '0, seed = 32'h8FED;
   logic [31:0] s_axi_rdata, loc_rdata, xop_rdata, yop_rdata, sys_rdata;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hF, loc_be = 4'hF, sys_be = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
   logic s_axi_rready = '0, loc_req = '0, loc_we = '0, xop_req = '0, xop_we = '0;
   logic yop_req = '0, yop_we = '0, sys_req = '0, sys_we = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, loc_ack;
   logic loc_err, xop_ack, xop_err, yop_ack, yop_err, sys_ack, sys_err, sys_bus_req, sys_bus_gnt;
   int n_fail = 0;
   int n_compared = 0;
   xym_multiport dut (.*);
   xym_arb_model arb (.aclk, .aresetn, .hold_cyc, .sys_bus_req, .sys_bus_gnt);
   always #12.5 aclk = ~aclk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Logical address of a word: X or Y memory, page, word index
   function automatic logic [31:0] la(input logic y, input logic p, input logic [9:0] i);
      return {15'h5280, y, p ? 4'h8 : 4'h7, i, 2'h0};
   endfunction
   // System bus latency in edges: ratio wait, or the longer bus hold
   function automatic int sys_min(input int h);
      return (h + 1 > int'(XYM_SYS_RATIO) ? h + 1 : int'(XYM_SYS_RATIO)) + 2;
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Register write; address and data released each as it is taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
            @(posedge aclk);
            return;
         end
      end
      n_fail++;
      finish_test();
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            s_axi_rready <= 1'h0;
            @(posedge aclk);
            return;
         end
      end
      n_fail++;
      finish_test();
   endtask
   // One access on the local (s=0) or system (s=1) bus; c counts edges after the take
   task automatic acc(input logic s, input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e, output int c);
      if (s) {sys_we, sys_addr, sys_wdata, sys_req} <= {w, a, d, 1'h1};
      else {loc_we, loc_addr, loc_wdata, loc_req} <= {w, a, d, 1'h1};
      for (c = 0; c < 40; c++)
      begin
         @(posedge aclk);
         if (s ? sys_ack : loc_ack)
         begin
            q = s ? sys_rdata : loc_rdata;
            e = s ? sys_err : loc_err;
            if (s) sys_req <= 1'h0;
            else loc_req <= 1'h0;
            @(posedge aclk);
            return;
         end
      end
      n_fail++;
      finish_test();
   endtask
   initial
   begin
      logic [31:0] q, d;
      logic [1:0] r;
      logic e;
      int c, c2;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axi_rd(XYM_OFS_CTRL, q);
      chk("ctrl reset", q, {27'h0, XYM_CTRL_RST});
      axi_wr(12'h00C, 32'h1, r);
      chk("unmapped resp", {30'h0, r}, {30'h0, XYM_RESP_SLVERR});
      acc(1'h0, 1'h0, la(1'h0, 1'h0, 10'h3), '0, q, e, c);
      chk("user local err", {31'h0, e}, 32'h1);
      $display("reset and user mode test done");
      // Each direct mode: random word written in one cycle and read back
      for (int m = 1; m < 4; m++)
      begin
         axi_wr(XYM_OFS_CTRL, 32'(m), r);
         d = rnd();
         acc(1'h0, 1'h1, la(d[0], d[1], d[11:2]), d, q, e, c);
         chk("local cycles", 32'(c), 32'h1);
         acc(1'h0, 1'h0, la(d[0], d[1], d[11:2]), '0, q, e, c);
         chk("local data", q, d);
      end
      acc(1'h0, 1'h1, la(d[0], d[1], d[11:2]) | 32'h2, ~d, q, e, c);
      chk("misaligned err", {31'h0, e}, 32'h1);
      acc(1'h0, 1'h0, la(d[0], d[1], d[11:2]), '0, q, e, c);
      chk("misaligned kept", q, d);
      $display("direct mode test done");
      // X and Y operand writes together, local read of the X word collides
      d = rnd();
      q = rnd();
      {xop_addr, xop_wdata, xop_we, xop_req} <= {q[31:16], 16'h7014, d, 2'h3};
      {yop_addr, yop_wdata, yop_we, yop_req} <= {~q[31:16], 16'h7014, ~d, 2'h3};
      fork
         acc(1'h0, 1'h0, la(1'h0, 1'h0, 10'h5), '0, q, e, c);
         begin
            repeat (2) @(posedge aclk);
            chk("xy one cycle", {28'h0, xop_ack, yop_ack, xop_err, yop_err}, 32'hC);
            {xop_req, yop_req} <= 2'h0;
         end
      join
      chk("op before local", q, d);
      chk("local retried", {31'h0, c > 1}, 32'h1);
      acc(1'h0, 1'h0, la(1'h1, 1'h0, 10'h5), '0, q, e, c);
      chk("y low half decode", q, ~d);
      $display("operand bus test done");
      for (int h = 0; h < 9; h += 8)
      begin
         hold_cyc <= 4'(h);
         d = rnd();
         acc(1'h1, 1'h1, la(1'h1, 1'h1, d[9:0]) & 32'h1FFFFFFF, d, q, e, c);
         chk("sys latency", 32'(c), 32'(sys_min(h)));
         acc(1'h0, 1'h0, la(1'h1, 1'h1, d[9:0]), '0, q, e, c);
         chk("sys write seen", q, d);
         acc(1'h1, 1'h0, la(1'h1, 1'h1, d[9:0]) & 32'h1FFFFFFF, '0, q, e, c);
         chk("sys read back", q, d);
      end
      acc(1'h1, 1'h0, la(1'h0, 1'h0, 10'h0), '0, q, e, c);
      chk("sys top bits err", {31'h0, e}, 32'h1);
      axi_wr(XYM_OFS_CTRL, 32'h13, r);
      acc(1'h1, 1'h0, la(1'h0, 1'h1, 10'h0) & 32'h1FFFFFFF, '0, q, e, c);
      chk("sleep sys err", {31'h0, e}, 32'h1);
      // Four refused accesses so far, one page conflict cycle
      axi_rd(XYM_OFS_STAT, q);
      chk("stat counts", q, 32'h00040001);
      $display("system bus test done");
      finish_test();
   end
endmodule
